// ==== frontend_diag_pkg.sv ====
// Constants shared by the front-end diagnostics configuration block
// Behaviour
// - One format bit picks differential or single-ended temperature mux output; upper bits unused.
// - Global diagnostics enable bit: one turns checking on, zero off; bits 1-7 unused.
// - Memory lock bit: locked refuses memory access, unlocked allows it.
// - Three-bit code picks undervoltage 5 to 30 percent, overvoltage 95 to 70 percent.
// - Bit five disables resistor checks on the pressure sense pins.
// - Bit six disables resistor checks on temperature sense pins; bit seven unused.
// - Input detector enables: pressure over bit 0, under bit 1, temperature over bit 2.
// - Output detector enables: pressure over 4, under 5, temperature over 6, under 7.
// - Width select one gives 24-bit compensation data, zero gives 16-bit.
package frontend_diag_pkg;

   // ==========================================================================
   // Register indices; byte address is four times the index
   localparam logic [31:0] TEMP_PATH_FORMAT_IDX = 32'h4000003A;
   localparam logic [31:0] FAULT_CHECK_CONTROL_IDX = 32'h40000056;
   localparam logic [31:0] NVM_LOCK_CONTROL_IDX = 32'h40000057;
   localparam logic [31:0] FRONTEND_FAULT_CONFIG_IDX = 32'h40000058;
   localparam logic [31:0] FRONTEND_FAULT_ENABLES_IDX = 32'h40000059;
   localparam logic [31:0] CONVERSION_WIDTH_SELECT_IDX = 32'h40000068;
   localparam logic [31:0] EVENT_STATUS_IDX = 32'h40000070;
   localparam logic [31:0] EVENT_MASK_IDX = 32'h40000071;

   // ==========================================================================
   // Reset values
   localparam logic [7:0] TEMP_PATH_FORMAT_RST = 8'h00;
   localparam logic [7:0] FAULT_CHECK_CONTROL_RST = 8'h00;
   localparam logic [7:0] NVM_LOCK_CONTROL_RST = 8'h00;
   localparam logic [7:0] FRONTEND_FAULT_CONFIG_RST = 8'h00;
   localparam logic [7:0] FRONTEND_FAULT_ENABLES_RST = 8'h00;
   localparam logic [7:0] CONVERSION_WIDTH_SELECT_RST = 8'h01;
   localparam logic [7:0] EVENT_MASK_RST = 8'h00;

   // ==========================================================================
   // Writable bits of each register; the rest read as zero
   localparam logic [7:0] ONE_BIT_MASK = 8'h01;
   localparam logic [7:0] FAULT_CONFIG_MASK = 8'h7F;
   localparam logic [7:0] FAULT_ENABLES_MASK = 8'hF7;

   // ==========================================================================
   // Field positions
   localparam int PULLDOWN_SEL_LO_POS = 0;
   localparam int PULLDOWN_SEL_HI_POS = 1;
   localparam int WINDOW_LEVEL_LSB = 2;
   localparam int PRESSURE_RCHECK_OFF_POS = 5;
   localparam int TEMP_RCHECK_OFF_POS = 6;
   localparam int NVM_REFUSED_EVENT_POS = 3;
   localparam int FAULT_COUNT = 8;

   // ==========================================================================
   // Undervoltage limit in tenths of a percent of bridge supply
   localparam logic [9:0] LIMIT_FULL_SCALE = 10'h3E8;
   localparam logic [9:0] UNDER_LIMIT_TABLE [8] = '{
      10'h032, 10'h04B, 10'h064, 10'h07D, 10'h096, 10'h0C8, 10'h0FA, 10'h12C};

   // Pull-down strength in megaohms, indexed by {hi, lo}
   localparam logic [2:0] PULLDOWN_TABLE [4] = '{3'h4, 3'h2, 3'h3, 3'h1};

   // ==========================================================================
   // Bus slave states
   typedef enum logic [1:0] {BUS_IDLE, BUS_WRITE, BUS_READ_WAIT, BUS_READ_DONE} bus_state_t;

endpackage

// ==== reg_access_if.sv ====
// Register strobe bundle between the bus slave and the register file
`timescale 1ns/1ps
`default_nettype none
interface reg_access_if;
   logic wr;
   logic rd;
   logic [29:0] index;
   logic [31:0] wdata;
   logic [31:0] rdata;
   modport bus (output wr, output rd, output index, output wdata, input rdata);
   modport regs (input wr, input rd, input index, input wdata, output rdata);
endinterface
`default_nettype wire

// ==== ahb_reg_port.sv ====
// AHB-Lite slave that turns bus transfers into register strobes
`timescale 1ns/1ps
`default_nettype none
module ahb_reg_port
   import frontend_diag_pkg::*;
(
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic [2:0] hsize,
   input wire logic hwrite,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   reg_access_if.bus regPort
);
   import frontend_diag_pkg::*;

   bus_state_t state;
   logic [29:0] addrIndex;
   logic accept;

   // ==========================================================================
   // Only whole-word transfers are taken; others complete with no effect
   assign accept = hsel && htrans[1] && hready && (hsize == 3'h2) && (state != BUS_READ_WAIT);

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         state <= BUS_IDLE;
         addrIndex <= '0;
      end else if (accept) begin
         state <= hwrite ? BUS_WRITE : BUS_READ_WAIT;
         addrIndex <= haddr[31:2];
      end else begin
         unique case (state)
            BUS_IDLE: state <= BUS_IDLE;
            BUS_WRITE: state <= BUS_IDLE;
            BUS_READ_WAIT: state <= BUS_READ_DONE;
            BUS_READ_DONE: state <= BUS_IDLE;
         endcase
      end
   end

   // One wait state on reads so the data reflects a write just before it
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         hreadyout <= 1'b1;
         hrdata <= '0;
         hresp <= 1'b0;
      end else begin
         hreadyout <= !(accept && !hwrite);
         hresp <= 1'b0;
         if (state == BUS_READ_WAIT) begin
            hrdata <= regPort.rdata;
         end
      end
   end

   assign regPort.wr = (state == BUS_WRITE);
   assign regPort.rd = (state == BUS_READ_WAIT);
   assign regPort.index = addrIndex;
   assign regPort.wdata = hwdata;
endmodule
`default_nettype wire

// ==== fault_qualifier.sv ====
// Synchronises raw detector levels and gates them with their enables
`timescale 1ns/1ps
`default_nettype none
module fault_qualifier #(
   parameter int WIDTH = 8
) (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic [WIDTH-1:0] rawFault,
   input wire logic [WIDTH-1:0] detectorOn,
   input wire logic globalOn,
   output logic [WIDTH-1:0] faultFlags
);
   logic [WIDTH-1:0] syncStage1;
   logic [WIDTH-1:0] syncStage2;

   // ==========================================================================
   // Comparator outputs are asynchronous to this clock
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         syncStage1 <= '0;
         syncStage2 <= '0;
      end else begin
         syncStage1 <= rawFault;
         syncStage2 <= syncStage1;
      end
   end

   generate
      for (genvar i = 0; i < WIDTH; i++) begin : g_gate
         always_ff @(posedge ref_clk) begin
            if (reset) begin
               faultFlags[i] <= 1'b0;
            end else begin
               faultFlags[i] <= syncStage2[i] && detectorOn[i] && globalOn;
            end
         end
      end
   endgenerate
endmodule
`default_nettype wire

// ==== frontend_diag_config_regs.sv ====
// Front-end diagnostics configuration registers with AHB-Lite access
`timescale 1ns/1ps
`default_nettype none
module frontend_diag_config_regs
   import frontend_diag_pkg::*;
(
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic [2:0] hsize,
   input wire logic hwrite,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   input wire logic [7:0] rawFault,
   input wire logic nvmAccessReq,
   output logic nvmAccessGrant,
   output logic temp_path_single_ended_sel,
   output logic fault_check_on,
   output logic nvmLocked,
   output logic [2:0] pulldownMegohm,
   output logic [9:0] sense_low_limit,
   output logic [9:0] sense_high_limit,
   output logic pressure_pin_rcheck_off,
   output logic temp_pin_rcheck_off,
   output logic [7:0] faultFlags,
   output logic wide_conversion_sel,
   output logic irq
);
   import frontend_diag_pkg::*;

   // ==========================================================================
   // Storage
   reg_access_if regBus ();

   logic [7:0] temp_path_format;
   logic [7:0] fault_check_control;
   logic [7:0] nvm_lock_control;
   logic [7:0] frontend_fault_config;
   logic [7:0] frontend_fault_enables;
   logic [7:0] conversion_width_select;
   logic [7:0] eventStatus;
   logic [7:0] eventMask;
   logic [7:0] qualifiedFault;
   logic nvmRefused;

   logic selTempFormat;
   logic selFaultCheck;
   logic selNvmLock;
   logic selFaultConfig;
   logic selFaultEnables;
   logic selWidth;
   logic selStatus;
   logic selMask;
   logic [7:0] wByte;
   logic [2:0] windowCode;
   logic [1:0] pulldownCode;
   logic [7:0] next_eventStatus;

   // ==========================================================================
   // Bus slave
   ahb_reg_port ahb_reg_port_inst (
      .ref_clk(ref_clk),
      .reset(reset),
      .hsel(hsel),
      .haddr(haddr),
      .htrans(htrans),
      .hsize(hsize),
      .hwrite(hwrite),
      .hwdata(hwdata),
      .hready(hready),
      .hreadyout(hreadyout),
      .hrdata(hrdata),
      .hresp(hresp),
      .regPort(regBus.bus)
   );

   // ==========================================================================
   // Address decode
   assign selTempFormat = (regBus.index == TEMP_PATH_FORMAT_IDX[29:0]);
   assign selFaultCheck = (regBus.index == FAULT_CHECK_CONTROL_IDX[29:0]);
   assign selNvmLock = (regBus.index == NVM_LOCK_CONTROL_IDX[29:0]);
   assign selFaultConfig = (regBus.index == FRONTEND_FAULT_CONFIG_IDX[29:0]);
   assign selFaultEnables = (regBus.index == FRONTEND_FAULT_ENABLES_IDX[29:0]);
   assign selWidth = (regBus.index == CONVERSION_WIDTH_SELECT_IDX[29:0]);
   assign selStatus = (regBus.index == EVENT_STATUS_IDX[29:0]);
   assign selMask = (regBus.index == EVENT_MASK_IDX[29:0]);
   assign wByte = regBus.wdata[7:0];

   // ==========================================================================
   // Configuration registers; unused bits are never stored
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         temp_path_format <= TEMP_PATH_FORMAT_RST;
      end else if (regBus.wr && selTempFormat) begin
         temp_path_format <= wByte & ONE_BIT_MASK;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         fault_check_control <= FAULT_CHECK_CONTROL_RST;
      end else if (regBus.wr && selFaultCheck) begin
         fault_check_control <= wByte & ONE_BIT_MASK;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         nvm_lock_control <= NVM_LOCK_CONTROL_RST;
      end else if (regBus.wr && selNvmLock) begin
         nvm_lock_control <= wByte & ONE_BIT_MASK;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         frontend_fault_config <= FRONTEND_FAULT_CONFIG_RST;
      end else if (regBus.wr && selFaultConfig) begin
         frontend_fault_config <= wByte & FAULT_CONFIG_MASK;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         frontend_fault_enables <= FRONTEND_FAULT_ENABLES_RST;
      end else if (regBus.wr && selFaultEnables) begin
         frontend_fault_enables <= wByte & FAULT_ENABLES_MASK;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         conversion_width_select <= CONVERSION_WIDTH_SELECT_RST;
      end else if (regBus.wr && selWidth) begin
         conversion_width_select <= wByte & ONE_BIT_MASK;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         eventMask <= EVENT_MASK_RST;
      end else if (regBus.wr && selMask) begin
         eventMask <= wByte;
      end
   end

   // ==========================================================================
   // Read mux; unmapped addresses read zero
   always_comb begin
      regBus.rdata = '0;
      if (selTempFormat) begin
         regBus.rdata[7:0] = temp_path_format;
      end else if (selFaultCheck) begin
         regBus.rdata[7:0] = fault_check_control;
      end else if (selNvmLock) begin
         regBus.rdata[7:0] = nvm_lock_control;
      end else if (selFaultConfig) begin
         regBus.rdata[7:0] = frontend_fault_config;
      end else if (selFaultEnables) begin
         regBus.rdata[7:0] = frontend_fault_enables;
      end else if (selWidth) begin
         regBus.rdata[7:0] = conversion_width_select;
      end else if (selStatus) begin
         regBus.rdata[7:0] = eventStatus;
      end else if (selMask) begin
         regBus.rdata[7:0] = eventMask;
      end
   end

   // ==========================================================================
   // Detector qualification
   fault_qualifier #(
      .WIDTH(FAULT_COUNT)
   ) fault_qualifier_inst (
      .ref_clk(ref_clk),
      .reset(reset),
      .rawFault(rawFault),
      .detectorOn(frontend_fault_enables),
      .globalOn(fault_check_control[0]),
      .faultFlags(qualifiedFault)
   );

   // ==========================================================================
   // Memory access gate; request is a same-clock level
   assign nvmRefused = nvmAccessReq && nvm_lock_control[0];

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         nvmAccessGrant <= 1'b0;
      end else begin
         nvmAccessGrant <= nvmAccessReq && !nvm_lock_control[0];
      end
   end

   // ==========================================================================
   // Sticky events; a new event in the clearing read's cycle survives
   always_comb begin
      next_eventStatus = eventStatus;
      if (regBus.rd && selStatus) begin
         next_eventStatus = '0;
      end
      next_eventStatus = next_eventStatus | qualifiedFault;
      next_eventStatus[NVM_REFUSED_EVENT_POS] = next_eventStatus[NVM_REFUSED_EVENT_POS] | nvmRefused;
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         eventStatus <= '0;
      end else begin
         eventStatus <= next_eventStatus;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         irq <= 1'b0;
      end else begin
         irq <= |(next_eventStatus & eventMask);
      end
   end

   // ==========================================================================
   // Decoded configuration outputs
   assign windowCode = frontend_fault_config[WINDOW_LEVEL_LSB +: 3];
   assign pulldownCode = {frontend_fault_config[PULLDOWN_SEL_HI_POS],
                          frontend_fault_config[PULLDOWN_SEL_LO_POS]};

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         temp_path_single_ended_sel <= 1'b0;
         fault_check_on <= 1'b0;
         nvmLocked <= 1'b0;
         wide_conversion_sel <= 1'b1;
      end else begin
         temp_path_single_ended_sel <= temp_path_format[0];
         fault_check_on <= fault_check_control[0];
         nvmLocked <= nvm_lock_control[0];
         wide_conversion_sel <= conversion_width_select[0];
      end
   end

   // Limits are tenths of a percent so the half-percent codes stay exact
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         sense_low_limit <= UNDER_LIMIT_TABLE[0];
         sense_high_limit <= LIMIT_FULL_SCALE - UNDER_LIMIT_TABLE[0];
      end else begin
         sense_low_limit <= UNDER_LIMIT_TABLE[windowCode];
         sense_high_limit <= LIMIT_FULL_SCALE - UNDER_LIMIT_TABLE[windowCode];
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         pulldownMegohm <= PULLDOWN_TABLE[0];
         pressure_pin_rcheck_off <= 1'b0;
         temp_pin_rcheck_off <= 1'b0;
      end else begin
         pulldownMegohm <= PULLDOWN_TABLE[pulldownCode];
         pressure_pin_rcheck_off <= frontend_fault_config[PRESSURE_RCHECK_OFF_POS];
         temp_pin_rcheck_off <= frontend_fault_config[TEMP_RCHECK_OFF_POS];
      end
   end

   assign faultFlags = qualifiedFault;
endmodule
`default_nettype wire

// ==== frontend_diag_config_regs_asserts.sv ====
// Concurrent checks on the diagnostics configuration register ports
`timescale 1ns/1ps
`default_nettype none
module frontend_diag_config_regs_asserts (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic hsel,
   input wire logic [1:0] htrans,
   input wire logic [2:0] hsize,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic nvmAccessReq,
   input wire logic nvmAccessGrant,
   input wire logic nvmLocked,
   input wire logic fault_check_on,
   input wire logic [7:0] faultFlags,
   input wire logic wide_conversion_sel,
   input wire logic [2:0] pulldownMegohm,
   input wire logic [9:0] sense_low_limit,
   input wire logic [9:0] sense_high_limit
);
   // ==========
   // Port relations
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (reset);
   property p_limit_sum;
      (sense_low_limit + sense_high_limit) == 10'h3E8;
   endproperty
   a_limit_sum: assert property (p_limit_sum) else $error("limits not complementary");
   property p_low_set;
      sense_low_limit inside {10'h032, 10'h04B, 10'h064, 10'h07D, 10'h096, 10'h0C8, 10'h0FA, 10'h12C};
   endproperty
   a_low_set: assert property (p_low_set) else $error("low limit off table");
   property p_pulldown;
      pulldownMegohm inside {[3'h1:3'h4]};
   endproperty
   a_pulldown: assert property (p_pulldown) else $error("pull-down off table");
   property p_reset_vals;
      $fell(reset) |-> wide_conversion_sel && pulldownMegohm == 3'h4 && sense_low_limit == 10'h032;
   endproperty
   a_reset_vals: assert property (p_reset_vals) else $error("bad values after reset");
   // Lock and grant both lag the register, so two locked samples rule out any grant
   property p_grant_refused;
      nvmLocked && $past(nvmLocked) |-> !nvmAccessGrant;
   endproperty
   a_grant_refused: assert property (p_grant_refused) else $error("grant while locked");
   property p_grant_given;
      !$past(reset) && $past(nvmAccessReq) && !nvmLocked && !$past(nvmLocked) |-> nvmAccessGrant;
   endproperty
   a_grant_given: assert property (p_grant_given) else $error("no grant while unlocked");
   property p_flags_off;
      !fault_check_on [*3] |-> faultFlags == 8'h00;
   endproperty
   a_flags_off: assert property (p_flags_off) else $error("flag while checks off");
   property p_no_bit3;
      faultFlags[3] == 1'b0;
   endproperty
   a_no_bit3: assert property (p_no_bit3) else $error("unused detector flagged");
   property p_read_wait;
      hsel && htrans[1] && hready && !hwrite && hsize == 3'h2 && hreadyout |=> !hreadyout ##1 hreadyout;
   endproperty
   a_read_wait: assert property (p_read_wait) else $error("read wait state wrong");
   property p_okay;
      hresp == 1'b0;
   endproperty
   a_okay: assert property (p_okay) else $error("error response");
endmodule
bind frontend_diag_config_regs frontend_diag_config_regs_asserts checker_inst (
   .ref_clk(ref_clk), .reset(reset), .hsel(hsel), .htrans(htrans), .hsize(hsize),
   .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
   .nvmAccessReq(nvmAccessReq), .nvmAccessGrant(nvmAccessGrant), .nvmLocked(nvmLocked),
   .fault_check_on(fault_check_on), .faultFlags(faultFlags),
   .wide_conversion_sel(wide_conversion_sel), .pulldownMegohm(pulldownMegohm),
   .sense_low_limit(sense_low_limit), .sense_high_limit(sense_high_limit));
`default_nettype wire

// ==== tb_frontend_diag_config_regs.sv ====
// Self-checking bench for the diagnostics configuration registers
`timescale 1ns/1ps
`default_nettype none
module tb_frontend_diag_config_regs;
   import frontend_diag_pkg::*;
   // ==========
   // Signals and expected tables
   logic ref_clk, reset, hsel, hwrite, hready, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0] htrans;
   logic [2:0] hsize, pulldownMegohm;
   logic [7:0] rawFault, faultFlags;
   logic nvmAccessReq, nvmAccessGrant, irq, wide_conversion_sel;
   logic temp_path_single_ended_sel, fault_check_on, nvmLocked;
   logic pressure_pin_rcheck_off, temp_pin_rcheck_off;
   logic [9:0] sense_low_limit, sense_high_limit;
   int fails, num_checks;
   localparam logic [31:0] REG_IDX [7] = '{TEMP_PATH_FORMAT_IDX, FAULT_CHECK_CONTROL_IDX,
      NVM_LOCK_CONTROL_IDX, FRONTEND_FAULT_CONFIG_IDX, FRONTEND_FAULT_ENABLES_IDX,
      CONVERSION_WIDTH_SELECT_IDX, EVENT_MASK_IDX};
   localparam logic [7:0] REG_RST [7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00};
   // Unused bits drop, so all-ones reads back as the writable set
   localparam logic [7:0] REG_BITS [7] = '{8'h01, 8'h01, 8'h01, 8'h7F, 8'hF7, 8'h01, 8'hFF};
   localparam logic [9:0] UNDER_TENTHS [8] = '{10'h032, 10'h04B, 10'h064, 10'h07D, 10'h096,
      10'h0C8, 10'h0FA, 10'h12C};
   localparam logic [2:0] PD_MEG [4] = '{3'h4, 3'h2, 3'h3, 3'h1};
   assign hready = hreadyout;
   frontend_diag_config_regs frontend_diag_config_regs_inst (.ref_clk(ref_clk), .reset(reset),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hsize(hsize), .hwrite(hwrite),
      .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
      .rawFault(rawFault), .nvmAccessReq(nvmAccessReq), .nvmAccessGrant(nvmAccessGrant),
      .temp_path_single_ended_sel(temp_path_single_ended_sel), .fault_check_on(fault_check_on),
      .nvmLocked(nvmLocked), .pulldownMegohm(pulldownMegohm), .sense_low_limit(sense_low_limit),
      .sense_high_limit(sense_high_limit), .pressure_pin_rcheck_off(pressure_pin_rcheck_off),
      .temp_pin_rcheck_off(temp_pin_rcheck_off), .faultFlags(faultFlags),
      .wide_conversion_sel(wide_conversion_sel), .irq(irq));
   // ==========
   // Bus and compare tasks
   function automatic logic [31:0] addr(input logic [31:0] idx);
      return {idx[29:0], 2'b00};
   endfunction
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
   endtask
   task automatic chk_val(input logic [31:0] got, input logic [31:0] exp, input string what);
      num_checks++;
      if (got !== exp) begin
         fails++;
         $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   // Bounded so a stuck slave is reported here rather than only by the watchdog
   task automatic wait_ready();
      int n;
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (hreadyout !== 1'b1 && n < 20);
      chk_val(32'({hreadyout, hresp}), 32'h2, "bus ready");
   endtask
   task automatic bus_access(input logic wr, input logic [31:0] a, input logic [31:0] d);
      htrans <= 2'b10;
      hwrite <= wr;
      haddr <= a;
      wait_ready();
      htrans <= 2'b00;
      hwdata <= d;
      wait_ready();
      rd = hrdata;
   endtask
   task automatic reg_check(input logic [31:0] a, input logic [31:0] exp, input string what);
      bus_access(1'b0, a, 32'h0);
      chk_val(rd, exp, what);
   endtask
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // ==========
   // Clock, watchdog and tests
   initial begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end
   initial begin
      #50000;
      fails++;
      give_verdict();
   end
   initial begin
      reset = 1'b1;
      hsel = 1'b1;
      haddr = 32'h0;
      htrans = 2'b00;
      hsize = 3'h2;
      hwrite = 1'b0;
      hwdata = 32'h0;
      rawFault = 8'h00;
      nvmAccessReq = 1'b0;
      fails = 0;
      num_checks = 0;
      repeat (5) @(posedge ref_clk);
      reset <= 1'b0;
      @(posedge ref_clk);
      chk_val(32'({wide_conversion_sel, pulldownMegohm}), 32'hC, "reset outputs");
      chk_val(32'({sense_low_limit, sense_high_limit}), 32'h0000CBB6, "reset limits");
      for (int i = 0; i < 7; i++) begin
         reg_check(addr(REG_IDX[i]), 32'(REG_RST[i]), "reset value");
      end
      for (int i = 0; i < 7; i++) begin
         bus_access(1'b1, addr(REG_IDX[i]), 32'hFFFFFFFF);
         reg_check(addr(REG_IDX[i]), 32'(REG_BITS[i]), "unused bits");
      end
      chk_val(32'({temp_path_single_ended_sel, fault_check_on, nvmLocked, wide_conversion_sel}),
         32'hF, "bits set");
      bus_access(1'b1, 32'h00000200, 32'hFFFFFFFF);
      reg_check(32'h00000200, 32'h0, "unmapped");
      nvmAccessReq <= 1'b1;
      tick(3);
      chk_val(32'({nvmAccessGrant, irq}), 32'h1, "locked access");
      nvmAccessReq <= 1'b0;
      reg_check(addr(EVENT_STATUS_IDX), 32'h08, "refusal event");
      reg_check(addr(EVENT_STATUS_IDX), 32'h00, "status cleared");
      chk_val(32'(irq), 32'h0, "irq after clear");
      bus_access(1'b1, addr(NVM_LOCK_CONTROL_IDX), 32'h0);
      nvmAccessReq <= 1'b1;
      tick(3);
      chk_val(32'({nvmAccessGrant, nvmLocked}), 32'h2, "unlocked access");
      nvmAccessReq <= 1'b0;
      for (int i = 0; i < 8; i++) begin
         logic [2:0] c;
         c = 3'(i);
         bus_access(1'b1, addr(FRONTEND_FAULT_CONFIG_IDX), 32'({c[0], c[1], c, c[1:0]}));
         tick(3);
         chk_val(32'(sense_low_limit), 32'(UNDER_TENTHS[i]), "low limit");
         chk_val(32'(sense_high_limit), 32'h3E8 - 32'(UNDER_TENTHS[i]), "high limit");
         chk_val(32'(pulldownMegohm), 32'(PD_MEG[c[1:0]]), "pull-down");
         chk_val(32'({pressure_pin_rcheck_off, temp_pin_rcheck_off}), 32'({c[1], c[0]}),
            "resistor checks");
      end
      for (int i = 0; i < 8; i++) begin
         rawFault <= 8'(1 << i);
         tick(5);
         chk_val(32'(faultFlags), (i == 3) ? 32'h0 : 32'h1 << i, "one detector");
      end
      rawFault <= 8'h00;
      tick(5);
      chk_val(32'(irq), 32'h1, "irq raised");
      reg_check(addr(EVENT_STATUS_IDX), 32'hF7, "fault events");
      bus_access(1'b1, addr(EVENT_MASK_IDX), 32'h00);
      rawFault <= 8'h10;
      tick(5);
      chk_val(32'({faultFlags[4], irq}), 32'h2, "masked event");
      bus_access(1'b1, addr(EVENT_MASK_IDX), 32'h10);
      tick(2);
      chk_val(32'(irq), 32'h1, "unmasked event");
      rawFault <= 8'hFF;
      bus_access(1'b1, addr(FRONTEND_FAULT_ENABLES_IDX), 32'h30);
      tick(5);
      chk_val(32'(faultFlags), 32'h30, "detector enables");
      bus_access(1'b1, addr(FAULT_CHECK_CONTROL_IDX), 32'h0);
      tick(5);
      chk_val(32'({faultFlags, fault_check_on}), 32'h0, "global off");
      rawFault <= 8'h00;
      bus_access(1'b1, addr(CONVERSION_WIDTH_SELECT_IDX), 32'h0);
      bus_access(1'b1, addr(TEMP_PATH_FORMAT_IDX), 32'h0);
      // A byte-sized write must leave the register untouched
      hsize <= 3'h0;
      bus_access(1'b1, addr(TEMP_PATH_FORMAT_IDX), 32'h1);
      hsize <= 3'h2;
      tick(3);
      chk_val(32'({wide_conversion_sel, temp_path_single_ended_sel}), 32'h0, "cleared");
      give_verdict();
   end
endmodule
`default_nettype wire
